// ===== core/tta_alert.sv
// thermal threshold compare, sticky alert pending and interrupt line
`timescale 1ns/10ps
`default_nettype none
`include "tta_defs.svh"

module tta_alert
  import tta_pkg::*;
#(
  parameter int NUM_DOM = `TTA_NUM_DOM,
  parameter int TEMP_W  = `TTA_TEMP_W
) (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic                           ce,
  input  wire logic [NUM_DOM-1:0][TEMP_W-1:0] temp_data,
  input  wire logic [NUM_DOM-1:0]             temp_tgl,
  input  wire tta_thr_wr_t                    thr_wr,
  input  wire logic                           irq_en,
  input  wire logic [NUM_DOM-1:0]             alert_clr,
  output logic      [NUM_DOM-1:0]             alert_event_r,
  output logic      [NUM_DOM-1:0]             alert_pend_r,
  output logic      [NUM_DOM-1:0][TEMP_W-1:0] temp_r,
  output logic                                thermal_alert_irq_line
);

  localparam int IRQ_NUM = `TTA_IRQ_NUM;  // position on the processor side

  logic [NUM_DOM-1:0][TEMP_W-1:0] thr_r;
  logic [NUM_DOM-1:0]             upd;
  logic [NUM_DOM-1:0]             seen_r;
  logic [NUM_DOM-1:0]             above;
  logic [NUM_DOM-1:0]             above_r;
  logic [NUM_DOM-1:0]             pend_nxt;
  logic                           irq_r;

  // write decode, shared by the store and its check
  function automatic logic thr_hit(input tta_thr_wr_t w, input int d);
    thr_hit = w.valid && (int'(w.dom) == d);
  endfunction

  // -----------------------------------------------------------------------
  // per-domain crossing, threshold and compare
  // -----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_DOM; g++) begin : g_dom
      tta_word_sync #(
        .W (TEMP_W)
      ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .tgl_in  (temp_tgl[g]),
        .data_in (temp_data[g]),
        .data_r  (temp_r[g]),
        .upd_r   (upd[g])
      );

      // threshold resets to full scale so only a full-scale reading fires before setup
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          thr_r[g] <= TEMP_W'(`TTA_THR_RST);
        end else if (ce && thr_hit(thr_wr, g)) begin
          thr_r[g] <= thr_wr.value;
        end
      end

      // no compare until a first real sample has arrived
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          seen_r[g] <= 1'b0;
        end else if (ce && upd[g]) begin
          seen_r[g] <= 1'b1;
        end
      end

      // reaching the limit counts, staying below never does
      assign above[g] = seen_r[g] && (temp_r[g] >= thr_r[g]);
    end
  endgenerate

  // -----------------------------------------------------------------------
  // event detection
  // -----------------------------------------------------------------------
  // edge of the crossing, so a steady level with a steady threshold gives
  // at most one event; both inputs are clk_sys flops, never raw words
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      above_r       <= '0;
      alert_event_r <= '0;
    end else if (ce) begin
      above_r       <= above;
      alert_event_r <= above & ~above_r;
    end
  end

  // -----------------------------------------------------------------------
  // sticky pending and interrupt
  // -----------------------------------------------------------------------
  // a new event in the clear cycle survives; earlier ones are discarded
  assign pend_nxt = (alert_pend_r & ~alert_clr) | alert_event_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alert_pend_r <= '0;
    end else if (ce) begin
      alert_pend_r <= pend_nxt;
    end
  end

  // registered so the line is glitch free across the OR of all domains and irq_en
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= irq_en && (|alert_pend_r);
    end
  end

  assign thermal_alert_irq_line = irq_r;

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  generate
    for (g = 0; g < NUM_DOM; g++) begin : g_chk
      sequence s_cross;
        ce && above[g] && !above_r[g];
      endsequence

      sequence s_quiet;
        ce && seen_r[g] && !upd[g] && !thr_hit(thr_wr, g);
      endsequence

      a_alert_needs_limit: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $rose(alert_event_r[g]) |-> $past(temp_r[g]) >= $past(thr_r[g]))
        else $error("alert raised below threshold");

      a_alert_on_cross: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        s_cross |=> alert_event_r[g] ##1 (!$past(ce) || !alert_event_r[g]))
        else $error("crossing did not give a single event");

      a_quiet_fixed_thr: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        s_quiet ##1 s_quiet |=> !alert_event_r[g])
        else $error("spurious alert with steady threshold");

      a_thr_store: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        ce && thr_hit(thr_wr, g) |=> thr_r[g] == $past(thr_wr.value))
        else $error("threshold write not stored");

      a_pend_sticky: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        ce && alert_pend_r[g] && !alert_clr[g] |=> alert_pend_r[g])
        else $error("pending flag dropped without clear");

      a_clear_discards: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        ce && alert_clr[g] && !alert_event_r[g] |=> !alert_pend_r[g])
        else $error("clear did not discard pending alert");

      a_set_beats_clear: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        ce && alert_event_r[g] |=> alert_pend_r[g])
        else $error("event lost against clear");
    end
  endgenerate

  a_irq_masked: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    ce && !irq_en |=> !thermal_alert_irq_line)
    else $error("irq raised while masked");

  a_irq_follows: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    ce && irq_en && (|alert_pend_r) |=> thermal_alert_irq_line)
    else $error("irq not asserted for enabled pending alert");

  // nothing pending means the line drops one cycle later
  a_irq_needs_pend: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    ce && !(|alert_pend_r) |=> !thermal_alert_irq_line)
    else $error("irq raised with nothing pending");

endmodule

`default_nettype wire

// ===== pkg/tta_defs.svh
// constants for the thermal threshold alert block
`ifndef TTA_DEFS_SVH
`define TTA_DEFS_SVH

// -----------------------------------------------------------------------
// geometry
// -----------------------------------------------------------------------
`define TTA_NUM_DOM  5
`define TTA_TEMP_W   10
`define TTA_DOM_W    3

// -----------------------------------------------------------------------
// domain indices on the threshold write port
// -----------------------------------------------------------------------
`define TTA_DOM_PROC 3'h0
`define TTA_DOM_GFX  3'h1
`define TTA_DOM_CORE 3'h2
`define TTA_DOM_DSP  3'h3
`define TTA_DOM_VID  3'h4

// -----------------------------------------------------------------------
// reset values and system numbering
// -----------------------------------------------------------------------
`define TTA_THR_RST  10'h3ff
`define TTA_IRQ_NUM  126

`endif

// ===== pkg/tta_pkg.sv
// types shared by the thermal threshold alert block
`include "tta_defs.svh"

package tta_pkg;

  // one threshold write from the software side, same clock as the block
  typedef struct packed {
    logic                   valid;
    logic [`TTA_DOM_W-1:0]  dom;
    logic [`TTA_TEMP_W-1:0] value;
  } tta_thr_wr_t;

endpackage

// ===== core/tta_word_sync.sv
// toggle-qualified word crossing from the sensor clock into clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "tta_defs.svh"

module tta_word_sync
  import tta_pkg::*;
#(
  parameter int W = `TTA_TEMP_W
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         tgl_in,
  input  wire logic [W-1:0] data_in,
  output logic      [W-1:0] data_r,
  output logic              upd_r
);

  logic         tgl_m_r;
  logic         tgl_s_r;
  logic         tgl_d_r;
  logic [W-1:0] data_m_r;
  logic [W-1:0] data_s_r;

  // -----------------------------------------------------------------------
  // synchronisers
  // -----------------------------------------------------------------------
  // first stages feed only second stages, nothing else looks at them
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tgl_m_r  <= 1'b0;
      tgl_s_r  <= 1'b0;
      tgl_d_r  <= 1'b0;
      data_m_r <= '0;
      data_s_r <= '0;
    end else if (ce) begin
      tgl_m_r  <= tgl_in;
      tgl_s_r  <= tgl_m_r;
      tgl_d_r  <= tgl_s_r;
      data_m_r <= data_in;
      data_s_r <= data_m_r;
    end
  end

  // -----------------------------------------------------------------------
  // capture
  // -----------------------------------------------------------------------
  // word is taken only once the toggle has settled, so it is never caught
  // mid-change; the sensor holds it steady from toggle to next toggle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_r <= '0;
      upd_r  <= 1'b0;
    end else if (ce) begin
      upd_r <= tgl_s_r ^ tgl_d_r;
      if (tgl_s_r ^ tgl_d_r) begin
        data_r <= data_s_r;
      end
    end
  end

  // held value moves only together with its update pulse
  a_word_held: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    $changed(data_r) |-> upd_r)
    else $error("synced word changed without an update");

  // an update pulse follows a settled toggle edge by one cycle
  a_update_pulse: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    ce && (tgl_s_r ^ tgl_d_r) |=> upd_r && data_r == $past(data_s_r))
    else $error("settled toggle did not load the word");

endmodule

`default_nettype wire

// ===== test/thermal_threshold_alert_tb_top.sv
// self-checking bench for the thermal threshold alert block
`timescale 1ns/10ps
`default_nettype none
`include "tta_defs.svh"

module thermal_threshold_alert_tb_top
  import tta_pkg::*;
;
  logic                 clk_sys;
  logic                 resetn;
  logic                 ce;
  logic                 irq_en;
  logic [4:0][9:0]      temp_data;
  logic [4:0]           temp_tgl;
  logic [4:0]           alert_clr;
  logic [4:0]           alert_event_r;
  logic [4:0]           alert_pend_r;
  logic [4:0][9:0]      temp_r;
  logic                 irq;
  logic [4:0]           ev_seen;
  logic                 ev_clr;
  tta_thr_wr_t          thr_wr;
  int                   num_errors;
  int                   checks_done;

  // -----------------------------------------------------------------
  // clock, device and event collector
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  tta_alert i_tta_alert (
    .clk_sys                (clk_sys),
    .resetn                 (resetn),
    .ce                     (ce),
    .temp_data              (temp_data),
    .temp_tgl               (temp_tgl),
    .thr_wr                 (thr_wr),
    .irq_en                 (irq_en),
    .alert_clr              (alert_clr),
    .alert_event_r          (alert_event_r),
    .alert_pend_r           (alert_pend_r),
    .temp_r                 (temp_r),
    .thermal_alert_irq_line (irq)
  );

  // event pulses last one cycle, so gather them here
  // one driver only; a clear request restarts the collection
  always @(posedge clk_sys) begin
    ev_seen <= ev_clr ? alert_event_r : (ev_seen | alert_event_r);
  end

  // -----------------------------------------------------------------
  // drivers and compares
  // -----------------------------------------------------------------
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_vec(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flags got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t temp got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t irq got %b exp %b", $time, got, exp);
    end
  endtask

  // word set a cycle ahead of its toggle and held long after it
  task automatic put_temp(input int d, input logic [9:0] v);
    temp_data[d] = v;
    cyc(1);
    temp_tgl[d] = ~temp_tgl[d];
    cyc(8);
    chk_word(temp_r[d], v);
  endtask

  task automatic ev_zero;
    ev_clr = 1'b1;
    cyc(1);
    ev_clr = 1'b0;
  endtask

  task automatic wr_thr(input logic [2:0] d, input logic [9:0] v);
    thr_wr = '{1'b1, d, v};
    cyc(1);
    thr_wr.valid = 1'b0;
    cyc(4);
  endtask

  task automatic clr(input logic [4:0] m);
    alert_clr = m;
    cyc(1);
    alert_clr = 5'h0_0;
    cyc(3);
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic sc_below;
    for (int d = 0; d < 5; d++) put_temp(d, 10'h3_fe);
    chk_vec(ev_seen, 5'h0_0);
    chk_bit(irq, 1'b0);
  endtask

  // threshold change under the safe sequence: the event it makes is
  // real, but the clear must discard it before the line is unmasked
  task automatic sc_update;
    irq_en = 1'b0;
    for (int d = 0; d < 5; d++) wr_thr(3'(d), 10'h2_00 + 10'(d));
    chk_vec(ev_seen, 5'h1_f);
    chk_bit(irq, 1'b0);
    clr(5'h1_f);
    chk_vec(alert_pend_r, 5'h0_0);
    irq_en = 1'b1;
    cyc(4);
    chk_bit(irq, 1'b0);
    chk_vec(alert_pend_r, 5'h0_0);
  endtask

  // each domain crosses its own limit exactly at the boundary
  task automatic sc_cross;
    for (int d = 0; d < 5; d++) put_temp(d, 10'h1_ff);
    ev_zero();
    for (int d = 0; d < 5; d++) begin
      put_temp(d, 10'h1_ff + 10'(d));
      chk_vec(ev_seen, 5'h0_0);
      put_temp(d, 10'h2_00 + 10'(d));
      chk_vec(ev_seen, 5'h0_1 << d);
      chk_bit(irq, 1'b1);
      ev_zero();
    end
    // all below again, so a stray write to any domain would fire
    for (int d = 0; d < 5; d++) put_temp(d, 10'h1_ff);
    ev_zero();
    wr_thr(3'h5, 10'h0_00);
    chk_vec(ev_seen, 5'h0_0);
  endtask

  // pending stays after the cause is gone; mask and clear gate the line
  task automatic sc_mask;
    put_temp(0, 10'h0_00);
    chk_vec(alert_pend_r, 5'h1_f);
    irq_en = 1'b0;
    cyc(2);
    chk_bit(irq, 1'b0);
    irq_en = 1'b1;
    cyc(2);
    chk_bit(irq, 1'b1);
    clr(5'h0_1);
    chk_vec(alert_pend_r, 5'h1_e);
    chk_bit(irq, 1'b1);
    clr(5'h1_e);
    chk_vec(alert_pend_r, 5'h0_0);
    chk_bit(irq, 1'b0);
  endtask

  // a frozen block must not take a toggle until the enable returns
  task automatic sc_freeze;
    ce = 1'b0;
    temp_data[1] = 10'h2_01;
    cyc(1);
    temp_tgl[1] = ~temp_tgl[1];
    cyc(8);
    chk_word(temp_r[1], 10'h1_ff);
    chk_vec(alert_pend_r, 5'h0_0);
    ce = 1'b1;
    cyc(8);
    chk_word(temp_r[1], 10'h2_01);
    chk_vec(alert_pend_r, 5'h0_2);
    chk_bit(irq, 1'b1);
  endtask

  // reset in mid-run clears all and restores full-scale thresholds
  task automatic sc_reset;
    resetn = 1'b0;
    cyc(1);
    chk_vec(alert_pend_r, 5'h0_0);
    chk_bit(irq, 1'b0);
    chk_word(temp_r[1], 10'h0_00);
    resetn = 1'b1;
    ev_zero();
    put_temp(1, 10'h3_fe);
    chk_vec(ev_seen, 5'h0_0);
  endtask

  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    num_errors = 0;
    checks_done = 0;
    resetn = 1'b0;
    ce = 1'b1;
    irq_en = 1'b1;
    temp_data = '0;
    temp_tgl = 5'h0_0;
    alert_clr = 5'h0_0;
    thr_wr = '0;
    ev_clr = 1'b1;
    cyc(6);
    resetn = 1'b1;
    ev_clr = 1'b0;
    chk_vec(alert_pend_r, 5'h0_0);
    chk_bit(irq, 1'b0);
    sc_below();
    sc_update();
    sc_cross();
    sc_mask();
    sc_freeze();
    sc_reset();
    final_report();
  end
endmodule

`default_nettype wire
